// [drt_timer.sv]
// Purpose: 16 bit auto reload timer, or two 8 bit auto reload timers
// Assumes: Byte register port synchronous to clk; interrupt enable from the
//          interrupt controller; clock select bits come from outside
// Notes:   Overflow flags stay set until software writes them low
`timescale 1ns/10ps
module drt_timer
    import drt_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              nrst,
    input  wire logic [7:0]        reg_addr,
    input  wire logic [DRT_DW-1:0] reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [DRT_DW-1:0] reg_rdata,
    input  wire logic              high_clock_select,
    input  wire logic              low_clock_select,
    input  wire logic              ext_clk,
    input  wire logic              irq_enable,
    output logic                   irq_req
);
    drt_tick_if ticks ();

    drt_tick_gen #(
        .SYS_DIV (DRT_SYS_DIV),
        .EXT_DIV (DRT_EXT_DIV)
    ) u_tick_gen (
        .clk     (clk),
        .nrst    (nrst),
        .ext_clk (ext_clk),
        .ticks   (ticks.gen)
    );

    logic [7:0] count_low_byte;
    logic [7:0] count_high_byte;
    logic [7:0] reload_low_byte;
    logic [7:0] reload_high_byte;
    logic       high_overflow_flag;
    logic       low_overflow_flag;
    logic       low_overflow_irq_enable;
    logic       split_mode_select;
    logic       run_control;
    logic       alt_clock_select;

    logic       wr_control;
    logic       wr_count_l;
    logic       wr_count_h;
    logic       tick_high;
    logic       tick_low;
    logic       step_word;
    logic       step_low;
    logic       step_high;
    logic       wrap_word;
    logic       wrap_low;
    logic       wrap_high;
    logic       set_high_flag;
    logic       set_low_flag;
    logic [7:0] next_count_low;
    logic [7:0] next_count_high;
    logic [7:0] control_view;

    // Tick source for one byte
    function automatic logic drt_pick_tick(input logic use_sys, input logic use_alt,
                                           input logic div_tick, input logic ext_tick);
        if (use_sys) begin
            return 1'b1;
        end
        return use_alt ? ext_tick : div_tick;
    endfunction : drt_pick_tick

    function automatic logic drt_hit(input logic wr, input logic [7:0] addr,
                                     input logic [7:0] target);
        return wr && (addr == target);
    endfunction : drt_hit

    assign wr_control = drt_hit(reg_wr, reg_addr, DRT_ADDR_CONTROL);
    assign wr_count_l = drt_hit(reg_wr, reg_addr, DRT_ADDR_COUNT_L);
    assign wr_count_h = drt_hit(reg_wr, reg_addr, DRT_ADDR_COUNT_H);

    assign tick_high = drt_pick_tick(high_clock_select, alt_clock_select,
                                     ticks.sys_div_tick, ticks.ext_div_tick);
    assign tick_low  = drt_pick_tick(low_clock_select, alt_clock_select,
                                     ticks.sys_div_tick, ticks.ext_div_tick);

    // Whole word uses the high byte source in 16 bit mode
    assign step_word = !split_mode_select && run_control && tick_high;
    assign step_low  = split_mode_select && tick_low;
    assign step_high = split_mode_select && run_control && tick_high;

    assign wrap_word = step_word &&
                       ({count_high_byte, count_low_byte} == DRT_WORD_ALL_ONES);
    assign wrap_low  = (step_word || step_low) &&
                       (count_low_byte == DRT_BYTE_ALL_ONES);
    assign wrap_high = step_high && (count_high_byte == DRT_BYTE_ALL_ONES);

    assign set_high_flag = wrap_word || wrap_high;
    assign set_low_flag  = wrap_low;

    always_comb begin
        next_count_low  = count_low_byte;
        next_count_high = count_high_byte;
        if (wrap_word) begin
            next_count_low  = reload_low_byte;
            next_count_high = reload_high_byte;
        end else if (step_word) begin
            next_count_low = count_low_byte + 8'h01;
            if (count_low_byte == DRT_BYTE_ALL_ONES) begin
                next_count_high = count_high_byte + 8'h01;
            end
        end else begin
            if (step_low) begin
                next_count_low = wrap_low ? reload_low_byte : count_low_byte + 8'h01;
            end
            if (step_high) begin
                next_count_high = wrap_high ? reload_high_byte
                                            : count_high_byte + 8'h01;
            end
        end
    end

    // Software write wins over a count step in the same cycle
    always_ff @(posedge clk) begin
        if (!nrst) begin
            count_low_byte <= DRT_RESET_BYTE;
        end else if (wr_count_l) begin
            count_low_byte <= reg_wdata;
        end else begin
            count_low_byte <= next_count_low;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            count_high_byte <= DRT_RESET_BYTE;
        end else if (wr_count_h) begin
            count_high_byte <= reg_wdata;
        end else begin
            count_high_byte <= next_count_high;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            reload_low_byte  <= DRT_RESET_BYTE;
            reload_high_byte <= DRT_RESET_BYTE;
        end else begin
            if (drt_hit(reg_wr, reg_addr, DRT_ADDR_RELOAD_L)) begin
                reload_low_byte <= reg_wdata;
            end
            if (drt_hit(reg_wr, reg_addr, DRT_ADDR_RELOAD_H)) begin
                reload_high_byte <= reg_wdata;
            end
        end
    end

    // Plain control bits; unused positions are not stored
    always_ff @(posedge clk) begin
        if (!nrst) begin
            low_overflow_irq_enable <= 1'b0;
            split_mode_select       <= 1'b0;
            run_control             <= 1'b0;
            alt_clock_select        <= 1'b0;
        end else if (wr_control) begin
            low_overflow_irq_enable <= reg_wdata[DRT_BIT_LOW_IRQEN];
            split_mode_select       <= reg_wdata[DRT_BIT_SPLIT];
            run_control             <= reg_wdata[DRT_BIT_RUN];
            alt_clock_select        <= reg_wdata[DRT_BIT_ALT_CLK];
        end
    end

    // Flags: only a software write clears; a same cycle overflow still sets
    always_ff @(posedge clk) begin
        if (!nrst) begin
            high_overflow_flag <= 1'b0;
            low_overflow_flag  <= 1'b0;
        end else begin
            high_overflow_flag <= (wr_control ? reg_wdata[DRT_BIT_HIGH_OVF]
                                              : high_overflow_flag) | set_high_flag;
            low_overflow_flag  <= (wr_control ? reg_wdata[DRT_BIT_LOW_OVF]
                                              : low_overflow_flag) | set_low_flag;
        end
    end

    always_comb begin
        control_view                    = 8'h00;
        control_view[DRT_BIT_HIGH_OVF]  = high_overflow_flag;
        control_view[DRT_BIT_LOW_OVF]   = low_overflow_flag;
        control_view[DRT_BIT_LOW_IRQEN] = low_overflow_irq_enable;
        control_view[DRT_BIT_SPLIT]     = split_mode_select;
        control_view[DRT_BIT_RUN]       = run_control;
        control_view[DRT_BIT_ALT_CLK]   = alt_clock_select;
    end

    // Read data held until the next read
    always_ff @(posedge clk) begin
        if (!nrst) begin
            reg_rdata <= DRT_RESET_BYTE;
        end else if (reg_rd) begin
            case (reg_addr)
                DRT_ADDR_CONTROL:  reg_rdata <= control_view;
                DRT_ADDR_RELOAD_L: reg_rdata <= reload_low_byte;
                DRT_ADDR_RELOAD_H: reg_rdata <= reload_high_byte;
                DRT_ADDR_COUNT_L:  reg_rdata <= count_low_byte;
                DRT_ADDR_COUNT_H:  reg_rdata <= count_high_byte;
                default:           reg_rdata <= DRT_UNMAPPED_READ;
            endcase
        end
    end

    // Level request from the registered flags; same form in both modes
    always_ff @(posedge clk) begin
        if (!nrst) begin
            irq_req <= 1'b0;
        end else begin
            irq_req <= irq_enable &&
                       (high_overflow_flag ||
                        (low_overflow_irq_enable && low_overflow_flag));
        end
    end
endmodule : drt_timer

// [drt_pkg.sv]
// Purpose: Shared constants for the dual mode reload timer
// Assumes: Byte wide register port with byte addresses
// Notes:   Offsets are the byte addresses seen on the register port
package drt_pkg;
    localparam int          DRT_DW            = 8;
    localparam logic [7:0]  DRT_ADDR_CONTROL  = 8'h91;
    localparam logic [7:0]  DRT_ADDR_RELOAD_L = 8'h92;
    localparam logic [7:0]  DRT_ADDR_RELOAD_H = 8'h93;
    localparam logic [7:0]  DRT_ADDR_COUNT_L  = 8'h94;
    localparam logic [7:0]  DRT_ADDR_COUNT_H  = 8'h95;

    // Control register field positions
    localparam int          DRT_BIT_HIGH_OVF  = 7;
    localparam int          DRT_BIT_LOW_OVF   = 6;
    localparam int          DRT_BIT_LOW_IRQEN = 5;
    localparam int          DRT_BIT_SPLIT     = 3;
    localparam int          DRT_BIT_RUN       = 2;
    localparam int          DRT_BIT_ALT_CLK   = 0;

    localparam logic [7:0]  DRT_RESET_BYTE    = 8'h00;
    localparam logic [7:0]  DRT_BYTE_ALL_ONES = 8'hff;
    localparam logic [15:0] DRT_WORD_ALL_ONES = 16'hffff;
    localparam logic [7:0]  DRT_UNMAPPED_READ = 8'h00;

    // Prescaler ratios
    localparam int          DRT_SYS_DIV       = 12;
    localparam int          DRT_EXT_DIV       = 8;
endpackage : drt_pkg

// [drt_tick_if.sv]
// Purpose: Carries prescaler tick pulses from the tick generator to the timer
// Assumes: One clock domain, ticks are one cycle pulses
// Notes:   Generator drives, timer core consumes
`timescale 1ns/10ps
interface drt_tick_if;
    logic sys_div_tick;
    logic ext_div_tick;

    modport gen (output sys_div_tick, output ext_div_tick);
    modport use_side (input sys_div_tick, input ext_div_tick);
endinterface : drt_tick_if

// [drt_tick_gen.sv]
// Purpose: Makes the system clock divided by 12 tick and the synchronised
//          external clock divided by 8 tick
// Assumes: External clock below half the system clock rate
// Notes:   Slower external clock only; faster clocks lose edges
`timescale 1ns/10ps
module drt_tick_gen
    import drt_pkg::*;
#(
    parameter int SYS_DIV = DRT_SYS_DIV,
    parameter int EXT_DIV = DRT_EXT_DIV
) (
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic ext_clk,
    drt_tick_if.gen   ticks
);
    localparam int SW = $clog2(SYS_DIV);
    localparam int EW = $clog2(EXT_DIV);
    localparam logic [SW-1:0] SYS_LAST = SW'(SYS_DIV - 1);
    localparam logic [EW-1:0] EXT_LAST = EW'(EXT_DIV - 1);

    logic [SW-1:0] sys_cnt;
    logic [EW-1:0] ext_cnt;
    logic          ext_meta;
    logic          ext_sync;
    logic          ext_prev;
    logic          ext_rise;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            sys_cnt            <= '0;
            ticks.sys_div_tick <= 1'b0;
        end else if (sys_cnt == SYS_LAST) begin
            sys_cnt            <= '0;
            ticks.sys_div_tick <= 1'b1;
        end else begin
            sys_cnt            <= sys_cnt + 1'b1;
            ticks.sys_div_tick <= 1'b0;
        end
    end

    // Two flop synchroniser; edge detect only on the second stage
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ext_meta <= 1'b0;
            ext_sync <= 1'b0;
            ext_prev <= 1'b0;
        end else begin
            ext_meta <= ext_clk;
            ext_sync <= ext_meta;
            ext_prev <= ext_sync;
        end
    end

    assign ext_rise = ext_sync & ~ext_prev;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            ext_cnt            <= '0;
            ticks.ext_div_tick <= 1'b0;
        end else if (ext_rise) begin
            ext_cnt            <= ext_cnt + 1'b1;
            ticks.ext_div_tick <= (ext_cnt == EXT_LAST);
        end else begin
            ticks.ext_div_tick <= 1'b0;
        end
    end
endmodule : drt_tick_gen

// [drt_timer_asserts.sv]
// Purpose: Port level checks for the dual mode reload timer
// Assumes: Only the top module ports are visible
// Notes:   Flag checks use software set flags, so no counting model is needed
`timescale 1ns/10ps
module drt_timer_asserts
    import drt_pkg::*;
(
    input wire logic              clk,
    input wire logic              nrst,
    input wire logic [7:0]        reg_addr,
    input wire logic [DRT_DW-1:0] reg_wdata,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [DRT_DW-1:0] reg_rdata,
    input wire logic              high_clock_select,
    input wire logic              low_clock_select,
    input wire logic              ext_clk,
    input wire logic              irq_enable,
    input wire logic              irq_req
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    wire ctl_wr = reg_wr && reg_addr == DRT_ADDR_CONTROL;
    wire ctl_rd = reg_rd && reg_addr == DRT_ADDR_CONTROL;

    sequence s_ctl_then_rd;
        ctl_wr ##1 (ctl_rd && !reg_wr);
    endsequence
    sequence s_rlh_then_rd;
        (reg_wr && reg_addr == DRT_ADDR_RELOAD_H) ##1 (reg_rd && reg_addr == DRT_ADDR_RELOAD_H);
    endsequence

    property p_unmapped;
        reg_rd && (reg_addr < DRT_ADDR_CONTROL || reg_addr > DRT_ADDR_COUNT_H)
            |=> reg_rdata == DRT_UNMAPPED_READ;
    endproperty
    property p_hold;
        !reg_rd |=> $stable(reg_rdata);
    endproperty
    property p_unused;
        ctl_rd |=> reg_rdata[4] == 1'b0 && reg_rdata[1] == 1'b0;
    endproperty
    property p_ctrl_rw;
        s_ctl_then_rd |=> (reg_rdata & 8'h2d) == ($past(reg_wdata, 2) & 8'h2d);
    endproperty
    property p_reload;
        s_rlh_then_rd |=> reg_rdata == $past(reg_wdata, 2);
    endproperty
    property p_irq_gate;
        !irq_enable |=> !irq_req;
    endproperty
    // Flags and low enable only fall on a control write
    property p_sticky;
        irq_req && irq_enable && !$past(ctl_wr) |=> irq_req;
    endproperty
    property p_high_irq;
        (ctl_wr && reg_wdata[DRT_BIT_HIGH_OVF]) ##1 irq_enable |=> irq_req;
    endproperty
    property p_low_irq;
        (ctl_wr && reg_wdata[DRT_BIT_LOW_OVF] && reg_wdata[DRT_BIT_LOW_IRQEN]) ##1 irq_enable
            |=> irq_req;
    endproperty

    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_hold: assert property (p_hold) else $error("read data moved without read");
    a_unused: assert property (p_unused) else $error("unused control bit set");
    a_ctrl_rw: assert property (p_ctrl_rw) else $error("control readback wrong");
    a_reload: assert property (p_reload) else $error("reload readback wrong");
    a_irq_gate: assert property (p_irq_gate) else $error("request while disabled");
    a_sticky: assert property (p_sticky) else $error("request dropped by itself");
    a_high_irq: assert property (p_high_irq) else $error("no request on high flag");
    a_low_irq: assert property (p_low_irq) else $error("no request on low flag");
endmodule : drt_timer_asserts

bind drt_timer drt_timer_asserts drt_timer_asserts_inst (.clk(clk), .nrst(nrst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .high_clock_select(high_clock_select),
    .low_clock_select(low_clock_select), .ext_clk(ext_clk), .irq_enable(irq_enable),
    .irq_req(irq_req));

// [dual_mode_reload_timer_tb.sv]
// Purpose: Self checking bench for the dual mode reload timer
// Assumes: Register writes take effect one cycle after the strobe edge
// Notes:   Strobes stay up between back to back accesses
`timescale 1ns/10ps
module dual_mode_reload_timer_tb;
    logic       clk = 0, nrst = 0, reg_wr = 0, reg_rd = 0, ext_clk = 0;
    logic       hcs = 0, lcs = 0, irq_enable = 0, irq_req;
    logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, v;
    int         err_total = 0, check_count = 0, cyc = 0;

    always #20 clk = ~clk;
    // Slower than clk and of unrelated phase
    always #43 ext_clk = ~ext_clk;

    drt_timer drt_timer_inst (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .high_clock_select(hcs), .low_clock_select(lcs), .ext_clk(ext_clk),
        .irq_enable(irq_enable), .irq_req(irq_req));

    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_sim

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            err_total++;
            end_sim();
        end
    end

    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        check_count++;
        if (s !== e) begin
            err_total++;
            $display("FAIL %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_rd = 0;
        reg_wr = 1;
        @(posedge clk) #1;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        reg_addr = a;
        reg_wr = 0;
        reg_rd = 1;
        @(posedge clk) #1;
        v = reg_rdata;
    endtask : rd
    task automatic wt(input int n);
        reg_wr = 0;
        reg_rd = 0;
        repeat (n) @(posedge clk);
        #1;
    endtask : wt

    task automatic t_regs;
        for (int a = 8'h91; a <= 8'h95; a++) begin
            rd(a[7:0]);
            chk("reset", v, 8'h00);
        end
        rd(8'h90);
        chk("unmapped", v, 8'h00);
        wr(8'h91, 8'h72);
        rd(8'h91);
        chk("unused", v, 8'h60);
        chk("irq low", {7'h00, irq_req}, 8'h01);
        wr(8'h91, 8'h80);
        wr(8'h91, 8'h00);
        wt(2);
        chk("irq clear", {7'h00, irq_req}, 8'h00);
        wr(8'h93, 8'h12);
        rd(8'h93);
        chk("reload h", v, 8'h12);
        wr(8'h92, 8'h34);
        rd(8'h92);
        chk("reload l", v, 8'h34);
        $display("done regs");
    endtask : t_regs

    task automatic t_wide;
        wr(8'h94, 8'hff);
        wr(8'h95, 8'hff);
        wr(8'h91, 8'h04);
        wr(8'h91, 8'h00);
        rd(8'h91);
        chk("flags", v, 8'hc0);
        rd(8'h94);
        chk("wrap l", v, 8'h34);
        rd(8'h95);
        chk("wrap h", v, 8'h12);
        chk("irq", {7'h00, irq_req}, 8'h01);
        rd(8'h94);
        chk("stopped", v, 8'h34);
        wr(8'h94, 8'hff);
        wr(8'h95, 8'h00);
        wr(8'h91, 8'h24);
        wr(8'h91, 8'h20);
        rd(8'h91);
        chk("low flag", v, 8'h60);
        rd(8'h95);
        chk("carry", v, 8'h01);
        chk("irq low", {7'h00, irq_req}, 8'h01);
        wr(8'h91, 8'h40);
        wt(2);
        chk("low masked", {7'h00, irq_req}, 8'h00);
        $display("done wide");
    endtask : t_wide

    task automatic t_split;
        wr(8'h95, 8'hff);
        wr(8'h91, 8'h08);
        wr(8'h94, 8'hff);
        rd(8'h94);
        chk("write", v, 8'hff);
        rd(8'h94);
        chk("reload l", v, 8'h34);
        rd(8'h94);
        chk("step", v, 8'h35);
        rd(8'h91);
        chk("low only", v, 8'h48);
        rd(8'h95);
        chk("high held", v, 8'hff);
        chk("no irq", {7'h00, irq_req}, 8'h00);
        wr(8'h91, 8'h0c);
        wr(8'h91, 8'h08);
        rd(8'h91);
        chk("high flag", v, 8'h88);
        rd(8'h95);
        chk("reload h", v, 8'h12);
        chk("irq high", {7'h00, irq_req}, 8'h01);
        wr(8'h91, 8'h28);
        wr(8'h94, 8'hff);
        wt(3);
        chk("irq low", {7'h00, irq_req}, 8'h01);
        rd(8'h91);
        chk("flags", v, 8'h68);
        $display("done split");
    endtask : t_split

    task automatic t_div12;
        wr(8'h91, 8'h00);
        wr(8'h94, 8'h00);
        wr(8'h95, 8'h00);
        wr(8'h91, 8'h04);
        wt(119);
        wr(8'h91, 8'h00);
        rd(8'h94);
        chk("div12", v, 8'h0a);
        $display("done div12");
    endtask : t_div12

    task automatic t_ext;
        wr(8'h94, 8'h00);
        wr(8'h95, 8'h00);
        wr(8'h91, 8'h0d);
        wt(320);
        wr(8'h91, 8'h09);
        rd(8'h95);
        chk("ext h", {7'h00, v >= 8'h11 && v <= 8'h14}, 8'h01);
        rd(8'h94);
        chk("ext l", {7'h00, v >= 8'h11 && v <= 8'h14}, 8'h01);
        $display("done ext");
    endtask : t_ext

    // A set flag must not request while the controller masks the timer
    task automatic t_gate;
        irq_enable = 0;
        wr(8'h91, 8'h80);
        wt(2);
        chk("gated", {7'h00, irq_req}, 8'h00);
        irq_enable = 1;
        wt(2);
        chk("ungated", {7'h00, irq_req}, 8'h01);
        wr(8'h91, 8'h00);
        wt(2);
        chk("cleared", {7'h00, irq_req}, 8'h00);
        $display("done gate");
    endtask : t_gate

    initial begin
        repeat (2) @(posedge clk);
        #1 nrst = 1;
        hcs = 1;
        lcs = 1;
        irq_enable = 1;
        t_regs();
        t_wide();
        t_split();
        hcs = 0;
        lcs = 0;
        t_div12();
        t_ext();
        t_gate();
        end_sim();
    end
endmodule : dual_mode_reload_timer_tb
